// file: adc_channel_decode.sv
// Channel and gain code decoder
`default_nettype none
module adc_channel_decode (
  input wire logic [5:0] code, // Channel and gain code
  input wire logic gain_select, // Picks the higher gain of each class
  output adc_pkg::source_sel_t sel // Decoded source
);
  logic high_class;
  logic [3:0] pos;
  logic [3:0] neg;

  always_comb begin
    high_class = ~code[0];
    pos = 4'h0;
    neg = 4'h0;
    case (code[5:1])
      5'h10: begin pos = 4'h0; neg = 4'h1; end
      5'h11: begin pos = 4'h1; neg = 4'h0; end
      5'h12: begin pos = 4'h1; neg = 4'h2; end
      5'h13: begin pos = 4'h2; neg = 4'h1; end
      5'h14: begin pos = 4'h2; neg = 4'h0; end
      5'h15: begin pos = 4'h0; neg = 4'h2; end
      5'h16: begin pos = 4'h4; neg = 4'h5; end
      5'h17: begin pos = 4'h5; neg = 4'h4; end
      5'h18: begin pos = 4'h5; neg = 4'h6; end
      5'h19: begin pos = 4'h6; neg = 4'h5; end
      5'h1a: begin pos = 4'h6; neg = 4'h4; end
      5'h1b: begin pos = 4'h4; neg = 4'h6; end
      5'h1c: begin pos = 4'h0; neg = 4'h0; end
      default: begin
        // Offset codes: same pin on both inputs, high gain only
        high_class = 1'b1;
        case (code[2:0])
          3'h2: begin pos = 4'h1; neg = 4'h1; end
          3'h3: begin pos = 4'h2; neg = 4'h2; end
          3'h4: begin pos = 4'h4; neg = 4'h4; end
          3'h5: begin pos = 4'h5; neg = 4'h5; end
          default: begin pos = 4'h6; neg = 4'h6; end
        endcase
      end
    endcase
  end

  always_comb begin
    sel = '0;
    if (code == adc_pkg::CODE_TEMP) begin
      sel.single_ended = 1'b1;
      sel.se_input = adc_pkg::INPUT_TEMP;
    end else if (!code[5]) begin
      sel.single_ended = 1'b1;
      sel.se_input = code[3:0];
    end else begin
      sel.differential = 1'b1;
      sel.pos_input = pos;
      sel.neg_input = neg;
      if (high_class) begin
        sel.gain = gain_select ? adc_pkg::GAIN_32X : adc_pkg::GAIN_20X;
      end else begin
        sel.gain = gain_select ? adc_pkg::GAIN_8X : adc_pkg::GAIN_1X;
      end
    end
  end
endmodule
`default_nettype wire

// file: adc_conversion_control.sv
// Converter conversion control with register port
// Function
// - Enable bit powers converter on and off
// - Clearing enable aborts a running conversion
// - Single mode: each start write converts once
// - Free running: one start, then continuous conversions
// - First conversion 25 cycles, later 13
// - First conversion runs initialization sequence
// - Start bit reads one while converting
// - Writing zero to start has no effect
// - Control/status bit layout, reset zero
// - Codes 100110/100111 select input 2 minus 1
// - Code 111111 selects temperature sensor
// - Gain select swaps 20x->32x, 1x->8x
// - Code MSB change applies after conversion
// - Done flag sets at each conversion end, as start bit clears in single mode
`default_nettype none
module adc_conversion_control (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [9:0] analog_result, // Converter result word
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  output logic converter_power, // Converter powered
  output logic conversion_active, // Conversion running
  output logic init_phase, // Initializing conversion running
  output logic conv_clk_en, // Converter clock enable
  output adc_pkg::source_sel_t source_sel, // Selected source
  output logic irq // Interrupt request level
);
  // Control/status A
  logic enable_r;
  logic start_r;
  logic auto_trig_r;
  logic done_flag_r;
  logic done_ie_r;
  logic [2:0] prescale_r;
  // Control/status B
  logic gain_sel_r;
  logic code_msb_r;
  logic [2:0] trig_src_r;
  // Channel low bits
  logic [4:0] chan_low_r;
  // Code MSB in use by the converter
  logic msb_active_r;
  logic [9:0] result_r;
  logic [adc_pkg::IRQ_W-1:0] irq_stat_r;
  logic [adc_pkg::IRQ_W-1:0] irq_mask_r;
  adc_pkg::conv_state_t state_r;
  logic first_r;
  logic [4:0] cnt_r;

  logic wr_csra;
  logic wr_csrb;
  logic new_enable;
  logic start_req;
  logic abort;
  logic tick;
  logic [4:0] conv_len;
  logic done_evt;
  logic free_run;
  logic restart;
  logic [5:0] code_now;
  adc_pkg::source_sel_t sel_now;
  logic [7:0] rd_mux;
  logic [adc_pkg::IRQ_W-1:0] irq_evt;

  assign wr_csra = reg_wr && (reg_addr == adc_pkg::OFF_CSRA);
  assign wr_csrb = reg_wr && (reg_addr == adc_pkg::OFF_CSRB);
  assign new_enable = reg_wdata[adc_pkg::BIT_ENABLE];

  // Start only when the same write sets the enable bit and no conversion is running
  assign start_req = wr_csra && reg_wdata[adc_pkg::BIT_START] && new_enable && !start_r;
  assign abort = wr_csra && !new_enable && start_r;

  assign conv_len = first_r ? adc_pkg::CYC_FIRST : adc_pkg::CYC_NORMAL;
  assign done_evt = (state_r == adc_pkg::ST_CONVERT) && tick && (cnt_r == conv_len - 5'd1) && !abort;
  assign free_run = auto_trig_r && (trig_src_r == adc_pkg::TS_FREE_RUN);
  assign restart = done_evt && free_run && enable_r && !(wr_csra && !new_enable);

  adc_prescaler u_prescaler (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(state_r == adc_pkg::ST_CONVERT),
    .sel(prescale_r),
    .tick(tick)
  );

  // Conversion sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= adc_pkg::ST_IDLE;
      cnt_r <= 5'd0;
    end else begin
      case (state_r)
        adc_pkg::ST_IDLE: begin
          if (start_req) begin
            state_r <= adc_pkg::ST_CONVERT;
            cnt_r <= 5'd0;
          end
        end
        adc_pkg::ST_CONVERT: begin
          if (abort) begin
            state_r <= adc_pkg::ST_IDLE;
            cnt_r <= 5'd0;
          end else if (done_evt) begin
            cnt_r <= 5'd0;
            if (!restart) begin
              state_r <= adc_pkg::ST_IDLE;
            end
          end else if (tick) begin
            cnt_r <= cnt_r + 5'd1;
          end
        end
        default: begin
          state_r <= adc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // First conversion after enabling carries initialization
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      first_r <= 1'b1;
    end else if (!enable_r) begin
      first_r <= 1'b1;
    end else if (done_evt) begin
      first_r <= 1'b0;
    end
  end

  // Enable bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enable_r <= 1'b0;
    end else if (wr_csra) begin
      enable_r <= new_enable;
    end
  end

  // Start bit: busy indicator
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      start_r <= 1'b0;
    end else if (abort) begin
      start_r <= 1'b0;
    end else if (start_req) begin
      start_r <= 1'b1;
    end else if (done_evt && !restart) begin
      start_r <= 1'b0;
    end
  end

  // Done flag: set wins over write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_flag_r <= 1'b0;
    end else if (done_evt) begin
      done_flag_r <= 1'b1;
    end else if (wr_csra && reg_wdata[adc_pkg::BIT_DONE_FLAG]) begin
      done_flag_r <= 1'b0;
    end
  end

  // Remaining control/status A fields
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      auto_trig_r <= 1'b0;
      done_ie_r <= 1'b0;
      prescale_r <= adc_pkg::RST_PS;
    end else if (wr_csra) begin
      auto_trig_r <= reg_wdata[adc_pkg::BIT_AUTO_TRIG];
      done_ie_r <= reg_wdata[adc_pkg::BIT_DONE_IE];
      prescale_r <= reg_wdata[adc_pkg::BIT_PS_HI:adc_pkg::BIT_PS_LO];
    end
  end

  // Control/status B and channel register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gain_sel_r <= 1'b0;
      code_msb_r <= 1'b0;
      trig_src_r <= 3'h0;
      chan_low_r <= 5'h00;
    end else begin
      if (wr_csrb) begin
        gain_sel_r <= reg_wdata[adc_pkg::BIT_GAIN_SEL];
        code_msb_r <= reg_wdata[adc_pkg::BIT_CODE_MSB];
        trig_src_r <= reg_wdata[adc_pkg::BIT_TS_HI:adc_pkg::BIT_TS_LO];
      end
      if (reg_wr && (reg_addr == adc_pkg::OFF_CHAN)) begin
        chan_low_r <= reg_wdata[adc_pkg::BIT_CHAN_HI:0];
      end
    end
  end

  // Code MSB follows the register only between conversions
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      msb_active_r <= 1'b0;
    end else if (state_r == adc_pkg::ST_IDLE || done_evt) begin
      msb_active_r <= code_msb_r;
    end
  end

  assign code_now = {msb_active_r, chan_low_r};

  adc_channel_decode u_decode (
    .code(code_now),
    .gain_select(gain_sel_r),
    .sel(sel_now)
  );

  // Result capture at the end of a conversion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_r <= 10'h000;
    end else if (done_evt) begin
      result_r <= analog_result;
    end
  end

  // Interrupt status and mask
  always_comb begin
    irq_evt = '0;
    irq_evt[adc_pkg::IRQ_DONE] = done_evt;
    irq_evt[adc_pkg::IRQ_ABORT] = abort;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (reg_wr && (reg_addr == adc_pkg::OFF_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata[adc_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (reg_wr && (reg_addr == adc_pkg::OFF_IRQ_MASK)) begin
        irq_mask_r <= reg_wdata[adc_pkg::IRQ_W-1:0];
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == adc_pkg::OFF_CSRA) begin
      rd_mux = {enable_r, start_r, auto_trig_r, done_flag_r, done_ie_r, prescale_r};
    end else if (reg_addr == adc_pkg::OFF_CSRB) begin
      rd_mux[adc_pkg::BIT_GAIN_SEL] = gain_sel_r;
      rd_mux[adc_pkg::BIT_CODE_MSB] = code_msb_r;
      rd_mux[adc_pkg::BIT_TS_HI:adc_pkg::BIT_TS_LO] = trig_src_r;
    end else if (reg_addr == adc_pkg::OFF_CHAN) begin
      rd_mux[adc_pkg::BIT_CHAN_HI:0] = chan_low_r;
    end else if (reg_addr == adc_pkg::OFF_RES_LO) begin
      rd_mux = result_r[7:0];
    end else if (reg_addr == adc_pkg::OFF_RES_HI) begin
      rd_mux[1:0] = result_r[9:8];
    end else if (reg_addr == adc_pkg::OFF_IRQ_STAT) begin
      rd_mux[adc_pkg::IRQ_W-1:0] = irq_stat_r;
    end else if (reg_addr == adc_pkg::OFF_IRQ_MASK) begin
      rd_mux[adc_pkg::IRQ_W-1:0] = irq_mask_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= adc_pkg::RST_REG;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Converter power follows the enable bit one cycle later
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      converter_power <= 1'b0;
    end else begin
      converter_power <= enable_r;
    end
  end

  // Busy indicator mirrors the start bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conversion_active <= 1'b0;
    end else begin
      conversion_active <= start_r;
    end
  end

  // Initialization runs only inside the first conversion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      init_phase <= 1'b0;
    end else begin
      init_phase <= start_r && first_r;
    end
  end

  // Converter clock enable, registered so the port comes from a flop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conv_clk_en <= 1'b0;
    end else begin
      conv_clk_en <= tick;
    end
  end

  // Decoded source, held stable between code or gain select changes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      source_sel <= '0;
    end else begin
      source_sel <= sel_now;
    end
  end

  // Level interrupt: unmasked status or enabled done flag
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(irq_stat_r & irq_mask_r)) || (done_flag_r && done_ie_r);
    end
  end
endmodule
`default_nettype wire

// file: adc_conversion_control_sva.sv
// Assertion checker for the conversion control block
`default_nettype none
module adc_conversion_control_chk (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic converter_power, // Converter powered
  input wire logic conversion_active, // Conversion running
  input wire logic init_phase, // Initializing conversion
  input wire logic conv_clk_en // Converter clock enable
);
  logic [5:0] tick_cnt_r;
  logic csra_wr;
  assign csra_wr = reg_wr && reg_addr == adc_pkg::OFF_CSRA;
  // Converter ticks within the current conversion
  always_ff @(posedge mclk) begin
    if (sys_rst || !conversion_active) begin
      tick_cnt_r <= 6'h00;
    end else if (conv_clk_en) begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_power_follows: assert property (csra_wr |-> ##2 converter_power == $past(reg_wdata[7], 2))
    else $error("converter power does not follow enable");
  a_off_idle: assert property (!converter_power |-> !conversion_active && !init_phase)
    else $error("conversion while unpowered");
  a_abort_now: assert property (conversion_active && csra_wr && !reg_wdata[7] |-> ##2 !conversion_active && !init_phase)
    else $error("conversion not aborted");
  a_start_unpowered: assert property (csra_wr && !reg_wdata[7] |-> ##2 !conversion_active)
    else $error("start taken while disabled");
  a_conv_length: assert property ($fell(conversion_active) && converter_power |->
    tick_cnt_r == ($past(init_phase) ? 6'h19 : 6'h0d))
    else $error("wrong conversion length");
  a_init_in_conv: assert property (init_phase |-> conversion_active)
    else $error("init phase outside conversion");
  a_start_readback: assert property (reg_rd && reg_addr == adc_pkg::OFF_CSRA |=>
    reg_rdata[adc_pkg::BIT_START] == conversion_active)
    else $error("start bit readback wrong");
  a_enable_readback: assert property (reg_rd && reg_addr == adc_pkg::OFF_CSRA |=>
    reg_rdata[adc_pkg::BIT_ENABLE] == converter_power)
    else $error("enable bit readback wrong");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < adc_pkg::OFF_CSRB || reg_addr > adc_pkg::OFF_IRQ_MASK)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind adc_conversion_control adc_conversion_control_chk i_chk (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .converter_power(converter_power), .conversion_active(conversion_active), .init_phase(init_phase),
  .conv_clk_en(conv_clk_en));
`default_nettype wire

// file: adc_pkg.sv
// Constants and types shared by the conversion control block
`default_nettype none
package adc_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CSRB = 8'h03;
  localparam logic [7:0] OFF_RES_LO = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h05;
  localparam logic [7:0] OFF_CSRA = 8'h06;
  localparam logic [7:0] OFF_CHAN = 8'h07;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h09;
  // Control/status A fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO_TRIG = 5;
  localparam int BIT_DONE_FLAG = 4;
  localparam int BIT_DONE_IE = 3;
  localparam int BIT_PS_HI = 2;
  localparam int BIT_PS_LO = 0;
  // Control/status B fields
  localparam int BIT_GAIN_SEL = 6;
  localparam int BIT_CODE_MSB = 3;
  localparam int BIT_TS_HI = 2;
  localparam int BIT_TS_LO = 0;
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  // Channel register field
  localparam int BIT_CHAN_HI = 4;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_W = 2;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] RST_PS = 3'h0;
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] CYC_FIRST = 5'd25;
  localparam logic [4:0] CYC_NORMAL = 5'd13;
  // Source codes
  localparam logic [5:0] CODE_TEMP = 6'h3f;
  localparam logic [3:0] INPUT_TEMP = 4'hb;
  localparam logic [5:0] GAIN_1X = 6'd1;
  localparam logic [5:0] GAIN_8X = 6'd8;
  localparam logic [5:0] GAIN_20X = 6'd20;
  localparam logic [5:0] GAIN_32X = 6'd32;

  typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_t;

  typedef struct packed {
    logic single_ended;
    logic [3:0] se_input;
    logic differential;
    logic [3:0] pos_input;
    logic [3:0] neg_input;
    logic [5:0] gain;
  } source_sel_t;
endpackage
`default_nettype wire

// file: adc_prescaler.sv
// Converter clock enable divider
`default_nettype none
module adc_prescaler (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic run, // Divider counts while high
  input wire logic [2:0] sel, // Division select
  output logic tick // One-cycle converter clock enable
);
  logic [6:0] cnt_r;
  logic [6:0] last;

  always_comb begin
    // Codes 0 and 1 both divide by two
    if (sel == 3'h0) begin
      last = 7'h01;
    end else begin
      last = 7'((8'h01 << sel) - 8'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb_adc_conversion_control.sv
// Self-checking testbench for the conversion control block
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_adc_conversion_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [9:0] analog_result = 10'h2a5;
  logic [7:0] reg_rdata;
  logic converter_power, conversion_active, init_phase, conv_clk_en, irq;
  adc_pkg::source_sel_t source_sel;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // Code, positive input, negative input; code bit 0 marks the low gain class
  logic [15:0] tbl [14] = '{16'h2621, 16'h2721, 16'h2820, 16'h2b02, 16'h2c45, 16'h2f54, 16'h3056,
    16'h3365, 16'h3464, 16'h3746, 16'h3800, 16'h3900, 16'h3a11, 16'h3e66};
  adc_conversion_control i_adc_conversion_control (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .analog_result(analog_result),
    .reg_rdata(reg_rdata), .converter_power(converter_power), .conversion_active(conversion_active),
    .init_phase(init_phase), .conv_clk_en(conv_clk_en), .source_sel(source_sel), .irq(irq));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask
  task automatic wait_idle();
    int i;
    repeat (3) settle();
    for (i = 0; i < 300 && conversion_active !== 1'b0; i++) settle();
    `CHK(conversion_active, 1'b0)
  endtask
  task automatic chk_diff(input logic [15:0] t, input logic g);
    logic [5:0] gexp;
    wr(adc_pkg::OFF_CSRB, {1'b0, g, 2'b00, t[13], 3'b000});
    wr(adc_pkg::OFF_CHAN, {3'b000, t[12:8]});
    settle();
    gexp = t[8] ? (g ? adc_pkg::GAIN_8X : adc_pkg::GAIN_1X) : (g ? adc_pkg::GAIN_32X : adc_pkg::GAIN_20X);
    `CHK(source_sel.differential, 1'b1)
    `CHK(source_sel.pos_input, t[7:4])
    `CHK(source_sel.neg_input, t[3:0])
    `CHK(source_sel.gain, gexp)
  endtask
  initial begin
    int k;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (k = 3; k <= 9; k++) rd(8'(k), 8'h00);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    // First conversion, started with the enabling write
    wr(adc_pkg::OFF_CSRA, 8'hc8);
    rd(adc_pkg::OFF_CSRA, 8'hc8);
    wr(adc_pkg::OFF_CSRA, 8'h88);
    rd(adc_pkg::OFF_CSRA, 8'hc8);
    wait_idle();
    rd(adc_pkg::OFF_CSRA, 8'h98);
    `CHK(irq, 1'b1)
    rd(adc_pkg::OFF_RES_LO, 8'ha5);
    rd(adc_pkg::OFF_RES_HI, 8'h02);
    rd(adc_pkg::OFF_IRQ_STAT, 8'h01);
    wr(adc_pkg::OFF_CSRA, 8'h90);
    rd(adc_pkg::OFF_CSRA, 8'h80);
    `CHK(irq, 1'b0)
    wr(adc_pkg::OFF_IRQ_MASK, 8'h01);
    rd(adc_pkg::OFF_IRQ_MASK, 8'h01);
    `CHK(irq, 1'b1)
    wr(adc_pkg::OFF_IRQ_STAT, 8'h01);
    rd(adc_pkg::OFF_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    // Code MSB changed in mid-conversion
    wr(adc_pkg::OFF_CSRB, 8'h08);
    wr(adc_pkg::OFF_CHAN, 8'h06);
    wr(adc_pkg::OFF_CSRA, 8'hc0);
    wr(adc_pkg::OFF_CSRB, 8'h00);
    settle();
    `CHK(source_sel.differential, 1'b1)
    wait_idle();
    `CHK(source_sel.single_ended, 1'b1)
    `CHK(source_sel.se_input, 4'h6)
    wr(adc_pkg::OFF_CSRA, 8'h90);
    // Abort by disabling
    wr(adc_pkg::OFF_CSRA, 8'hc0);
    repeat (6) @(posedge mclk);
    wr(adc_pkg::OFF_CSRA, 8'h00);
    rd(adc_pkg::OFF_CSRA, 8'h00);
    rd(adc_pkg::OFF_IRQ_STAT, 8'h03);
    wr(adc_pkg::OFF_CSRA, 8'h40);
    rd(adc_pkg::OFF_CSRA, 8'h00);
    `CHK(converter_power, 1'b0)
    // Free running
    wr(adc_pkg::OFF_CSRA, 8'he0);
    repeat (150) settle();
    `CHK(conversion_active, 1'b1)
    rd(adc_pkg::OFF_CSRA, 8'hf0);
    wr(adc_pkg::OFF_CSRA, 8'h00);
    for (k = 0; k < 28; k++) chk_diff(tbl[k / 2], k[0]);
    wr(adc_pkg::OFF_CSRB, 8'h08);
    wr(adc_pkg::OFF_CHAN, 8'h1f);
    settle();
    `CHK(source_sel.single_ended, 1'b1)
    `CHK(source_sel.se_input, adc_pkg::INPUT_TEMP)
    `CHK(source_sel.differential, 1'b0)
    `CHK(source_sel.gain, 6'h00)
    conclude();
  end
endmodule
`default_nettype wire
